/* rtl/clock_source_switch_monitor_pkg.sv */
// Purpose: shared constants for the clock source switch and monitor block
// Assumes: AXI4-Lite register access, one 32-bit word per register
// Notes: group codes follow the oscillator control register encoding
package clock_source_switch_monitor_pkg;
	// register byte addresses
	localparam logic [3:0] ADDR_OSC_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_RC_TRIM = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam int ADDR_W = 4;
	// oscillator control and rc trim register fields
	localparam int CURRENT_OSC_GROUP_LSB = 12;
	localparam int NEW_OSC_GROUP_LSB = 8;
	localparam int LOCK_BIT = 5;
	localparam int CF_BIT = 3;
	localparam int SECONDARY_OSC_ENABLE_BIT = 1;
	localparam int OSC_SWITCH_ENABLE_BIT = 0;
	localparam int TRIM_W = 6;
	localparam logic [5:0] TRIM_RESET = 6'h00;
	// oscillator group codes
	localparam logic [2:0] GRP_SECONDARY = 3'h0;
	localparam logic [2:0] GRP_FAST_RC = 3'h1;
	localparam logic [2:0] GRP_SLOW_RC = 3'h2;
	localparam logic [2:0] GRP_PRIMARY = 3'h3;
	localparam logic [2:0] GRP_PRIMARY_PLL = 3'h7;
	// source select one-hot positions
	localparam int SRC_PRI = 0;
	localparam int SRC_SEC = 1;
	localparam int SRC_FRC = 2;
	localparam int SRC_LRC = 3;
	// primary selection codes with the pll in circuit
	localparam logic [4:0] FPR_PLL_X4 = 5'h05;
	localparam logic [4:0] FPR_PLL_X8 = 5'h06;
	localparam logic [4:0] FPR_PLL_X16 = 5'h07;
	// pll multiplier output encoding
	localparam logic [1:0] MULT_OFF = 2'h0;
	localparam logic [1:0] MULT_X4 = 2'h1;
	localparam logic [1:0] MULT_X8 = 2'h2;
	localparam logic [1:0] MULT_X16 = 2'h3;
	// protected write key bytes
	localparam logic [7:0] KEY_FIRST = 8'h46;
	localparam logic [7:0] KEY_SECOND = 8'h57;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// break-before-make gap between two clock sources
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SWITCH_GAP_NS = 16;
	localparam int SWITCH_GAP_CYCLES = (SWITCH_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GAP_CNT_W = 4;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_GAP} sw_state_e;
endpackage : clock_source_switch_monitor_pkg

/* rtl/clock_source_switch_monitor.sv */
// Purpose: clock source selection, pll control, rc trim and fail-safe monitor
// Assumes: all inputs synchronous to REF_CLK; RSTN stands for power-on and brown-out reset
// Notes: source selects are one-hot, with an all-off gap on register and fail switches; strap changes select at once when switching is disabled
`timescale 1ns/1ps
module clock_source_switch_monitor
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RSTN,
	// configuration straps
	input wire logic [2:0] OSC_GROUP_CFG,
	input wire logic [4:0] PRIMARY_SELECT_CFG,
	input wire logic [1:0] CLOCK_MONITOR_CFG,
	// system status
	input wire logic POWERUP_TIMER_DONE,
	input wire logic SLEEP_MODE,
	input wire logic WATCHDOG_ENABLE,
	input wire logic SOFT_WATCHDOG_ENABLE,
	input wire logic PLL_LOCK_IN,
	input wire logic [3:0] SRC_RUNNING,
	// clock control outputs
	output logic [3:0] SRC_SELECT,
	output logic [1:0] PLL_MULT,
	output logic [5:0] FRC_TRIM,
	output logic SLOW_RC_ENABLE,
	output logic SECONDARY_OSC_ENABLE,
	output logic SYSCLK_HOLD,
	output logic CLOCK_FAIL_TRAP,
	// axi4-lite slave
	input wire logic [clock_source_switch_monitor_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [clock_source_switch_monitor_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	import clock_source_switch_monitor_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// decoding functions

	// within the primary group the option always follows the straps
	function automatic logic [2:0] resolve_group(input logic [2:0] grp, input logic [4:0] primary_select_config);
		logic [2:0] r;
		r = grp;
		if (grp == GRP_PRIMARY || grp == GRP_PRIMARY_PLL) begin
			r = (primary_select_config == FPR_PLL_X4 || primary_select_config == FPR_PLL_X8 || primary_select_config == FPR_PLL_X16) ? GRP_PRIMARY_PLL : GRP_PRIMARY;
		end
		return r;
	endfunction : resolve_group

	function automatic logic [3:0] group_onehot(input logic [2:0] grp);
		logic [3:0] r;
		r = 4'h0;
		case (grp)
			GRP_SECONDARY: r[SRC_SEC] = 1'b1;
			GRP_FAST_RC: r[SRC_FRC] = 1'b1;
			GRP_SLOW_RC: r[SRC_LRC] = 1'b1;
			GRP_PRIMARY, GRP_PRIMARY_PLL: r[SRC_PRI] = 1'b1;
			default: r = 4'h0;
		endcase
		return r;
	endfunction : group_onehot

	////////////////////////////////////////////////////////////////////////
	// state

	logic [2:0] current_osc_group_r, current_osc_group_nxt;
	logic [2:0] new_osc_group_r, new_osc_group_nxt;
	logic secondary_osc_enable_r, secondary_osc_enable_nxt;
	logic osc_switch_enable_r, osc_switch_enable_nxt;
	logic cf_r, cf_nxt;
	logic [5:0] trim_r, trim_nxt;
	logic [3:0] sel_r, sel_nxt;
	logic trap_r, trap_nxt;
	logic [2:0] target_r, target_nxt;
	logic [GAP_CNT_W-1:0] gap_r, gap_nxt;
	sw_state_e state_r, state_nxt;
	logic boot_r, boot_nxt;
	logic [1:0] key_r, key_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	logic switch_en, monitor_en, wr_go, rd_go, ctl_unlocked, ctl_wr, src_ok, fail;
	logic [15:0] osc_ctl_word, ctl_new;
	logic [2:0] cfg_group, want_group;

	assign switch_en = !CLOCK_MONITOR_CFG[1];
	assign monitor_en = CLOCK_MONITOR_CFG == 2'h0;
	assign cfg_group = resolve_group(OSC_GROUP_CFG, PRIMARY_SELECT_CFG);
	assign want_group = resolve_group(new_osc_group_r, PRIMARY_SELECT_CFG);

	assign osc_ctl_word = {1'b0, current_osc_group_r, 1'b0, new_osc_group_r, 2'h0, PLL_LOCK_IN, 1'b0, cf_r, 1'b0, secondary_osc_enable_r, osc_switch_enable_r};

	////////////////////////////////////////////////////////////////////////
	// bus handshake, one write and one read in flight

	assign S_AXI_AWREADY = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_r;
	assign S_AXI_WREADY = S_AXI_AWREADY;
	assign S_AXI_ARREADY = !rvalid_r;
	assign wr_go = S_AXI_AWREADY;
	assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
	assign ctl_wr = wr_go && S_AXI_AWADDR == ADDR_OSC_CONTROL;
	assign ctl_unlocked = key_r == 2'h2;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RRESP = rresp_r;
	assign S_AXI_RDATA = rdata_r;

	// byte-lane merge of an unlocked control write; read-only fields keep their value
	always_comb begin
		ctl_new = osc_ctl_word;
		if (S_AXI_WSTRB[0]) begin
			ctl_new[7:0] = S_AXI_WDATA[7:0];
		end
		if (S_AXI_WSTRB[1]) begin
			ctl_new[15:8] = S_AXI_WDATA[15:8];
		end
	end

	always_comb begin
		key_nxt = key_r;
		bvalid_nxt = bvalid_r && !S_AXI_BREADY;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r && !S_AXI_RREADY;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (wr_go) begin
			bvalid_nxt = 1'b1;
			bresp_nxt = (S_AXI_AWADDR == ADDR_OSC_CONTROL || S_AXI_AWADDR == ADDR_RC_TRIM) ? RESP_OKAY : RESP_SLVERR;
			// any write other than the next key byte drops the unlock
			key_nxt = 2'h0;
			if (ctl_wr && S_AXI_WSTRB == 4'h1 && key_r == 2'h0 && S_AXI_WDATA[7:0] == KEY_FIRST) begin
				key_nxt = 2'h1;
			end
			if (ctl_wr && S_AXI_WSTRB == 4'h1 && key_r == 2'h1 && S_AXI_WDATA[7:0] == KEY_SECOND) begin
				key_nxt = 2'h2;
			end
		end
		if (rd_go) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			case (S_AXI_ARADDR)
				ADDR_OSC_CONTROL: rdata_nxt = {16'h0000, osc_ctl_word};
				ADDR_RC_TRIM: rdata_nxt = {26'h0000000, trim_r};
				ADDR_STATUS: rdata_nxt = {24'h000000, SYSCLK_HOLD, SLOW_RC_ENABLE, state_r, PLL_MULT, 2'h0};
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			key_r <= 2'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h00000000;
		end else begin
			key_r <= key_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clock control and fail-safe monitor

	// the running source is lost, or the pll has no lock; also catches a slow start
	assign src_ok = |(group_onehot(current_osc_group_r) & SRC_RUNNING) && !(current_osc_group_r == GRP_PRIMARY_PLL && !PLL_LOCK_IN);
	assign fail = monitor_en && POWERUP_TIMER_DONE && !SLEEP_MODE && current_osc_group_r != GRP_FAST_RC && !src_ok;

	always_comb begin
		current_osc_group_nxt = current_osc_group_r;
		new_osc_group_nxt = new_osc_group_r;
		secondary_osc_enable_nxt = secondary_osc_enable_r;
		osc_switch_enable_nxt = osc_switch_enable_r;
		cf_nxt = cf_r;
		trim_nxt = trim_r;
		sel_nxt = sel_r;
		trap_nxt = 1'b0;
		target_nxt = target_r;
		gap_nxt = gap_r;
		state_nxt = state_r;
		boot_nxt = 1'b0;
		// first clock after reset: drive the strap-loaded group; later steps may override
		if (boot_r) begin
			sel_nxt = group_onehot(current_osc_group_r);
		end
		if (wr_go && S_AXI_AWADDR == ADDR_RC_TRIM && S_AXI_WSTRB[0]) begin
			trim_nxt = S_AXI_WDATA[TRIM_W-1:0];
		end
		if (ctl_wr && ctl_unlocked) begin
			new_osc_group_nxt = ctl_new[NEW_OSC_GROUP_LSB+:3];
			secondary_osc_enable_nxt = ctl_new[SECONDARY_OSC_ENABLE_BIT];
			osc_switch_enable_nxt = ctl_new[OSC_SWITCH_ENABLE_BIT];
		end
		case (state_r)
			ST_IDLE: begin
				if (osc_switch_enable_r && switch_en) begin
					state_nxt = ST_WAIT;
					target_nxt = want_group;
				end
			end
			ST_WAIT: begin
				// a switch hangs here until the target runs; clearing the enable escapes
				if (!osc_switch_enable_r) begin
					state_nxt = ST_IDLE;
				end else if (target_r == current_osc_group_r) begin
					osc_switch_enable_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end else if (|(group_onehot(target_r) & SRC_RUNNING)) begin
					sel_nxt = 4'h0;
					gap_nxt = GAP_CNT_W'(SWITCH_GAP_CYCLES - 1);
					state_nxt = ST_GAP;
				end
			end
			ST_GAP: begin
				if (gap_r != '0) begin
					gap_nxt = gap_r - 1'b1;
				end else begin
					current_osc_group_nxt = target_r;
					sel_nxt = group_onehot(target_r);
					osc_switch_enable_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		// failure outside ST_GAP overrides a waiting switch and clears the enable; a switch already in its gap completes first
		if (fail && state_r != ST_GAP) begin
			trap_nxt = 1'b1;
			cf_nxt = 1'b1;
			osc_switch_enable_nxt = 1'b0;
			target_nxt = GRP_FAST_RC;
			current_osc_group_nxt = GRP_FAST_RC;
			sel_nxt = 4'h0;
			gap_nxt = GAP_CNT_W'(SWITCH_GAP_CYCLES - 1);
			state_nxt = ST_GAP;
		end
		if (!switch_en) begin
			// straps select directly; the group field only reports
			current_osc_group_nxt = cfg_group;
			sel_nxt = group_onehot(cfg_group);
			osc_switch_enable_nxt = 1'b0;
			state_nxt = ST_IDLE;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			current_osc_group_r <= cfg_group;
			new_osc_group_r <= OSC_GROUP_CFG;
			secondary_osc_enable_r <= 1'b0;
			osc_switch_enable_r <= 1'b0;
			cf_r <= 1'b0;
			trim_r <= TRIM_RESET;
			sel_r <= 4'h0;
			trap_r <= 1'b0;
			target_r <= GRP_FAST_RC;
			gap_r <= '0;
			state_r <= ST_IDLE;
			boot_r <= 1'b1;
		end else begin
			current_osc_group_r <= current_osc_group_nxt;
			new_osc_group_r <= new_osc_group_nxt;
			secondary_osc_enable_r <= secondary_osc_enable_nxt;
			osc_switch_enable_r <= osc_switch_enable_nxt;
			cf_r <= cf_nxt;
			trim_r <= trim_nxt;
			sel_r <= sel_nxt;
			trap_r <= trap_nxt;
			target_r <= target_nxt;
			gap_r <= gap_nxt;
			state_r <= state_nxt;
			boot_r <= boot_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign SRC_SELECT = (current_osc_group_r == GRP_SECONDARY && !secondary_osc_enable_r) ? 4'h0 : sel_r;
	assign SECONDARY_OSC_ENABLE = secondary_osc_enable_r;
	assign FRC_TRIM = trim_r;
	assign CLOCK_FAIL_TRAP = trap_r;
	assign SYSCLK_HOLD = current_osc_group_r == GRP_PRIMARY_PLL && !PLL_LOCK_IN;

	always_comb begin
		PLL_MULT = MULT_OFF;
		if (current_osc_group_r == GRP_PRIMARY_PLL) begin
			// full code compare: straps may change after a switch latched the pll group
			case (PRIMARY_SELECT_CFG)
				FPR_PLL_X4: PLL_MULT = MULT_X4;
				FPR_PLL_X8: PLL_MULT = MULT_X8;
				FPR_PLL_X16: PLL_MULT = MULT_X16;
				default: PLL_MULT = MULT_OFF;
			endcase
		end
	end

	// watchdog clock is independent of the failure path
	assign SLOW_RC_ENABLE = !POWERUP_TIMER_DONE || (monitor_en && !SLEEP_MODE) || WATCHDOG_ENABLE
		|| SOFT_WATCHDOG_ENABLE || current_osc_group_r == GRP_SLOW_RC;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	a_fail_to_frc: assert property (fail && state_r != ST_GAP && switch_en |=> current_osc_group_r == GRP_FAST_RC && cf_r && !osc_switch_enable_r)
		else $error("failure did not load fast rc");
	a_trap_pulse: assert property (fail && state_r != ST_GAP && switch_en |=> CLOCK_FAIL_TRAP ##1 !CLOCK_FAIL_TRAP || fail)
		else $error("trap not raised on failure");
	a_cf_sticky: assert property (cf_r |=> cf_r)
		else $error("fail flag dropped");
	a_gap_off: assert property (state_r == ST_GAP |-> sel_r == 4'h0)
		else $error("source selected during gap");
	a_onehot_sel: assert property ($onehot0(sel_r))
		else $error("two sources selected");
	a_gap_len: assert property ($rose(state_r == ST_GAP) && switch_en |-> (state_r == ST_GAP)[*4] ##1 state_r != ST_GAP || !switch_en)
		else $error("gap length wrong");
	a_disabled_cfg: assert property (!switch_en |=> current_osc_group_r == $past(cfg_group) || switch_en)
		else $error("straps not followed");
	a_slow_rc_on: assert property (monitor_en && !SLEEP_MODE |-> SLOW_RC_ENABLE)
		else $error("slow rc off with monitor");
	a_hold_lock: assert property (current_osc_group_r == GRP_PRIMARY_PLL && !PLL_LOCK_IN |-> SYSCLK_HOLD)
		else $error("clock not held");
	a_key_unlock: assert property (key_r == 2'h2 && wr_go |=> key_r == 2'h0)
		else $error("unlock outlived one write");
	a_locked_write: assert property (ctl_wr && !ctl_unlocked && !fail && state_r == ST_IDLE && switch_en
		|=> new_osc_group_r == $past(new_osc_group_r))
		else $error("locked write changed new group");
	a_abort: assert property (state_r == ST_WAIT && !osc_switch_enable_r && !fail && switch_en |=> state_r == ST_IDLE)
		else $error("abort ignored");

	c_switch_done: cover property (state_r == ST_GAP ##1 state_r == ST_IDLE);
	c_fail_trap: cover property (CLOCK_FAIL_TRAP);
	c_unlock: cover property (key_r == 2'h1 ##1 key_r == 2'h2);
	c_abort: cover property (state_r == ST_WAIT ##1 state_r == ST_IDLE && !osc_switch_enable_r);
endmodule : clock_source_switch_monitor

/* tb/osc_source_model.sv */
// Purpose: behavioural oscillator sources and pll facing the clock block
// Assumes: every source runs unless the bench stops it
// Notes: lock needs the pll in circuit and a running primary source
`timescale 1ns/1ps
module osc_source_model
	import clock_source_switch_monitor_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// bench control
	input wire logic [3:0] stop_src,
	input wire logic [7:0] lock_delay,
	// block side
	input wire logic [1:0] pll_mult,
	output logic [3:0] src_running,
	output logic pll_lock
);
	logic [7:0] lock_cnt_r;
	assign src_running = ~stop_src;
	// lock drops at once, comes back only after the full delay
	always_ff @(posedge clk) begin
		if (!rstn || pll_mult == MULT_OFF || stop_src[SRC_PRI]) begin
			lock_cnt_r <= 8'h00;
			pll_lock <= 1'b0;
		end else if (lock_cnt_r == lock_delay) begin
			pll_lock <= 1'b1;
		end else begin
			lock_cnt_r <= lock_cnt_r + 8'h01;
		end
	end
endmodule : osc_source_model

/* tb/tb_clock_source_switch_monitor.sv */
// Purpose: self-checking bench for the clock source switch and monitor
// Assumes: register access over axi4-lite, oscillators from the source model
// Notes: hangs are cut by a cycle ceiling
`timescale 1ns/1ps
module tb_clock_source_switch_monitor;
	import clock_source_switch_monitor_pkg::*;
	localparam int LIMIT = 20000;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] grp_cfg = 3'h1;
	logic [4:0] pri_cfg = 5'h00;
	logic [1:0] mon_cfg = 2'h2;
	logic timer_done = 1'b0;
	logic sleep = 1'b0;
	logic wdt_en = 1'b0;
	logic swdt_en = 1'b0;
	logic [3:0] stop_src = 4'h0;
	logic [7:0] lock_delay = 8'h14;
	logic pll_lock, sec_en, hold, trap, slow_en;
	logic [3:0] running, src_sel;
	logic [1:0] pll_mult, bresp, rresp;
	logic [5:0] frc_trim;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [3:0] wstrb = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	clock_source_switch_monitor dut_u (.REF_CLK(clk), .RSTN(rstn), .OSC_GROUP_CFG(grp_cfg),
		.PRIMARY_SELECT_CFG(pri_cfg), .CLOCK_MONITOR_CFG(mon_cfg), .POWERUP_TIMER_DONE(timer_done),
		.SLEEP_MODE(sleep), .WATCHDOG_ENABLE(wdt_en), .SOFT_WATCHDOG_ENABLE(swdt_en), .PLL_LOCK_IN(pll_lock),
		.SRC_RUNNING(running), .SRC_SELECT(src_sel), .PLL_MULT(pll_mult), .FRC_TRIM(frc_trim),
		.SLOW_RC_ENABLE(slow_en), .SECONDARY_OSC_ENABLE(sec_en), .SYSCLK_HOLD(hold), .CLOCK_FAIL_TRAP(trap),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready));
	osc_source_model osc_u (.clk(clk), .rstn(rstn), .stop_src(stop_src), .lock_delay(lock_delay),
		.pll_mult(pll_mult), .src_running(running), .pll_lock(pll_lock));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL t=%0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			num_errors++;
			$display("FAIL t=%0t run did not finish", $time);
			end_sim();
		end
	end
	// two selects at once would mean overlapping clocks
	always @(negedge clk) begin
		if (rstn && $countones(src_sel) > 1)
			check(src_sel, 32'h0, "overlapping source selects");
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : tick
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
		check(r, er, "write response");
	endtask : axi_write
	task automatic axi_read(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
		logic ta, tr;
		logic [1:0] r;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end while (!tr);
		rready <= 1'b0;
		check(r, er, "read response");
	endtask : axi_read
	task automatic rd_check(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
		logic [31:0] d;
		axi_read(a, RESP_OKAY, d);
		check(d & mask, exp, what);
	endtask : rd_check
	task automatic ctl_write(input logic [31:0] d);
		axi_write(ADDR_OSC_CONTROL, {24'h0, KEY_FIRST}, 4'h1, RESP_OKAY);
		axi_write(ADDR_OSC_CONTROL, {24'h0, KEY_SECOND}, 4'h1, RESP_OKAY);
		axi_write(ADDR_OSC_CONTROL, d, 4'h3, RESP_OKAY);
	endtask : ctl_write
	task automatic do_reset(input logic [1:0] mon, input logic [2:0] grp);
		@(posedge clk);
		rstn <= 1'b0;
		mon_cfg <= mon;
		grp_cfg <= grp;
		stop_src <= 4'h0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
	endtask : do_reset
	// counts the all-off cycles seen before the wanted select
	task automatic wait_sel(input logic [3:0] exp, output int gap);
		int n;
		gap = 0;
		n = 0;
		while (src_sel !== exp && n < 200) begin
			@(negedge clk);
			if (src_sel === 4'h0) gap++;
			n++;
		end
		check(src_sel, exp, "source select");
	endtask : wait_sel
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_direct();
		do_reset(2'h2, GRP_FAST_RC);
		tick(3);
		check(slow_en, 1'b1, "slow rc before timer");
		check(src_sel, 4'h1 << SRC_FRC, "fast rc group");
		ctl_write(32'h0000_0201);
		tick(20);
		check(src_sel, 4'h1 << SRC_FRC, "switching disabled");
		rd_check(ADDR_OSC_CONTROL, 32'h7000, 32'h1000, "current group");
		@(posedge clk) timer_done <= 1'b1;
		tick(2);
		check(slow_en, 1'b0, "slow rc off");
		@(posedge clk) wdt_en <= 1'b1;
		tick(2);
		check(slow_en, 1'b1, "slow rc for watchdog");
		@(posedge clk) wdt_en <= 1'b0;
		swdt_en <= 1'b1;
		tick(2);
		check(slow_en, 1'b1, "slow rc for soft watchdog");
		@(posedge clk) swdt_en <= 1'b0;
		grp_cfg <= GRP_SLOW_RC;
		tick(3);
		check(slow_en, 1'b1, "slow rc selected");
		@(posedge clk) grp_cfg <= GRP_SECONDARY;
		tick(3);
		check(src_sel, 4'h0, "secondary without enable");
		ctl_write(32'h0000_0002);
		tick(3);
		check(src_sel, 4'h1 << SRC_SEC, "secondary enabled");
		check(sec_en, 1'b1, "secondary oscillator enable");
	endtask : t_direct
	task automatic t_pll();
		@(posedge clk) grp_cfg <= GRP_PRIMARY_PLL;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk) pri_cfg <= 5'h00;
			tick(2);
			@(posedge clk) pri_cfg <= FPR_PLL_X4 + 5'(i);
			tick(3);
			check(pll_mult, MULT_X4 + 2'(i), "pll multiplier");
			check(hold, 1'b1, "clock held before lock");
			tick(30);
			check(hold, 1'b0, "clock released on lock");
			rd_check(ADDR_OSC_CONTROL, 32'h0020, 32'h0020, "lock bit set");
		end
		@(posedge clk) stop_src <= 4'h1;
		tick(3);
		rd_check(ADDR_OSC_CONTROL, 32'h0020, 32'h0000, "lock bit withdrawn");
	endtask : t_pll
	task automatic t_trim();
		logic [5:0] codes [3] = '{6'h1F, 6'h20, 6'h00};
		logic [31:0] d;
		do_reset(2'h2, GRP_FAST_RC);
		rd_check(ADDR_RC_TRIM, 32'h3F, {26'h0, TRIM_RESET}, "trim reset");
		// no pll in circuit here, so the top code stays legal
		foreach (codes[i]) begin
			axi_write(ADDR_RC_TRIM, {26'h0, codes[i]}, 4'hF, RESP_OKAY);
			rd_check(ADDR_RC_TRIM, 32'h3F, {26'h0, codes[i]}, "trim readback");
			check(frc_trim, codes[i], "trim output");
		end
		axi_write(4'hC, 32'h1, 4'hF, RESP_SLVERR);
		axi_read(4'hC, RESP_SLVERR, d);
		check(d, 32'h0, "unmapped read data");
	endtask : t_trim
	task automatic t_switch();
		int gap;
		do_reset(2'h1, GRP_SLOW_RC);
		rd_check(ADDR_OSC_CONTROL, 32'h7700, 32'h2200, "groups from straps");
		check(src_sel, 4'h1 << SRC_LRC, "strap source after reset");
		do_reset(2'h1, GRP_FAST_RC);
		ctl_write(32'h0000_0201);
		wait_sel(4'h1 << SRC_LRC, gap);
		check(gap, SWITCH_GAP_CYCLES, "break before make gap");
		rd_check(ADDR_OSC_CONTROL, 32'h7701, 32'h2200, "switch done");
		axi_write(ADDR_OSC_CONTROL, 32'h0000_0301, 4'h3, RESP_OKAY);
		tick(10);
		rd_check(ADDR_OSC_CONTROL, 32'h0701, 32'h0200, "write without key");
		ctl_write(32'h0000_7200);
		rd_check(ADDR_OSC_CONTROL, 32'h7000, 32'h2000, "current group read-only");
		@(posedge clk) stop_src <= 4'h1;
		ctl_write(32'h0000_0301);
		tick(10);
		rd_check(ADDR_OSC_CONTROL, 32'h0001, 32'h0001, "switch pending");
		ctl_write(32'h0000_0300);
		tick(5);
		@(posedge clk) stop_src <= 4'h0;
		tick(20);
		check(src_sel, 4'h1 << SRC_LRC, "aborted switch");
		rd_check(ADDR_OSC_CONTROL, 32'h7001, 32'h2000, "abort keeps group");
	endtask : t_switch
	task automatic t_fail();
		int gap;
		int hi;
		do_reset(2'h0, GRP_FAST_RC);
		@(posedge clk) wdt_en <= 1'b1;
		// plain primary option: a pll target cannot lock before it is selected
		pri_cfg <= 5'h04;
		// primary is far above the monitor's lowest usable clock
		ctl_write(32'h0000_0301);
		wait_sel(4'h1 << SRC_PRI, gap);
		@(posedge clk) stop_src <= 4'h1;
		hi = 0;
		repeat (20) begin
			@(negedge clk);
			if (trap === 1'b1) hi++;
		end
		check(hi, 1, "one trap pulse");
		wait_sel(4'h1 << SRC_FRC, gap);
		rd_check(ADDR_OSC_CONTROL, 32'h7009, 32'h1008, "fail state");
		check(slow_en, 1'b1, "watchdog clock kept");
		@(posedge clk) wdt_en <= 1'b0;
		tick(2);
		check(slow_en, 1'b1, "slow rc with monitor");
	endtask : t_fail
	initial begin
		t_direct();
		t_pll();
		t_trim();
		t_switch();
		t_fail();
		end_sim();
	end
endmodule : tb_clock_source_switch_monitor
